// File: design/tmr_input_table_voter.sv
// Input polling, peer snapshot exchange and voted input table of one leg
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Poll every input module, refresh table
// - Device is bus master, CRC checked
// - Failed transfer repeated three more times
// - Exhausted retries load de-energized entry
// - Scan start snapshots table, sends to peers
// - Exchange starts on scan sync pulse
// - Own clock, aligned once per scan
// - Vote each point over three snapshots
// - Bad or silent peer table de-energized
// - Digital point is two-of-three majority
// - Digital defaults de-energized without majority
// - Analog point is median of three
// - Deviant leg alarmed, others averaged
module tmr_input_table_voter (
  input  wire logic                                 mclk,
  input  wire logic                                 nrst,
  output logic                                      io_req_valid,
  output logic [tmr_vote_pkg::IW-1:0]               io_req_addr,
  input  wire tmr_vote_pkg::word_in_t               io_rsp,
  input  wire logic                                 scan_time_sync,
  output logic                                      tx_valid,
  output logic [tmr_vote_pkg::DW-1:0]               tx_data,
  input  wire logic                                 tx_ready,
  input  wire tmr_vote_pkg::word_in_t               peer_rx [2],
  input  wire logic [tmr_vote_pkg::NANA-1:0][tmr_vote_pkg::DW-1:0] ana_limit,
  output logic [tmr_vote_pkg::NANA-1:0]             ana_alarm,
  output logic [1:0]                                peer_bad,
  output logic                                      scan_done,
  output logic                                      vote_valid,
  output logic [tmr_vote_pkg::DW-1:0]               vote_data,
  input  wire logic                                 vote_ready
);
  import tmr_vote_pkg::*;

  poll_st_t              pst_q, pst_d;
  logic [IW-1:0]         pidx_q, pidx_d;
  logic [1:0]            tries_q, tries_d;
  logic [11:0]           ptmr_q, ptmr_d;
  logic                  req_q, req_d;
  logic [DW-1:0]         itab_q [NW];
  logic [DW-1:0]         itab_d [NW];

  // Poll engine: one request, then wait for a good answer or give up
  always_comb begin
    pst_d   = pst_q;
    pidx_d  = pidx_q;
    tries_d = tries_q;
    ptmr_d  = ptmr_q;
    req_d   = 1'b0;
    itab_d  = itab_q;
    case (pst_q)
      P_SEND: begin
        req_d  = 1'b1;
        ptmr_d = 12'h000;
        pst_d  = P_WAIT;
      end
      P_WAIT: begin
        ptmr_d = ptmr_q + 12'h001;
        if (io_rsp.valid && io_rsp.crc_ok) begin
          itab_d[pidx_q] = io_rsp.data;
          pidx_d  = pidx_q + 2'h1;
          tries_d = 2'h0;
          pst_d   = P_SEND;
        end else if (io_rsp.valid || ptmr_q >= IO_TIMEOUT_CYC) begin
          if (tries_q == MAX_RETRY) begin
            itab_d[pidx_q] = DEENERGIZED;
            pidx_d  = pidx_q + 2'h1;
            tries_d = 2'h0;
          end else begin
            tries_d = tries_q + 2'h1;
          end
          pst_d = P_SEND;
        end
      end
      default: pst_d = P_SEND;
    endcase
  end

  // Poll registers; table starts de-energized so no stale data is voted
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pst_q   <= P_SEND;
      pidx_q  <= '0;
      tries_q <= 2'h0;
      ptmr_q  <= 12'h000;
      req_q   <= 1'b0;
      for (int i = 0; i < NW; i++) itab_q[i] <= DEENERGIZED;
    end else begin
      pst_q   <= pst_d;
      pidx_q  <= pidx_d;
      tries_q <= tries_d;
      ptmr_q  <= ptmr_d;
      req_q   <= req_d;
      itab_q  <= itab_d;
    end
  end

  assign io_req_valid = req_q;
  assign io_req_addr  = pidx_q;

  scan_st_t              sst_q, sst_d;
  logic [DW-1:0]         snap_q [NW];
  logic [DW-1:0]         snap_d [NW];
  logic [DW-1:0]         ptab_q [NPEER][NW];
  logic [DW-1:0]         ptab_d [NPEER][NW];
  logic [IW:0]           pcnt_q [NPEER];
  logic [IW:0]           pcnt_d [NPEER];
  logic [1:0]            bad_q, bad_d;
  logic [IW:0]           tcnt_q, tcnt_d;
  logic [IW-1:0]         ocnt_q, ocnt_d;
  logic [11:0]           stmr_q, stmr_d;
  logic                  txv_q, txv_d;
  logic [DW-1:0]         txd_q, txd_d;
  logic                  done_q, done_d;
  logic [NANA-1:0]       alm_q, alm_d;
  logic [DW-1:0]         voted [NW];
  logic [NANA-1:0]       dev_alarm;
  logic                  push;
  logic                  buf_ready;
  logic                  all_in;

  // Peer legs as seen by the voter, blanked when the peer failed
  logic [DW-1:0]         leg_b [NW];
  logic [DW-1:0]         leg_c [NW];

  function automatic logic [DW-1:0] absdiff(input logic [DW-1:0] x,
                                            input logic [DW-1:0] y);
    absdiff = (x > y) ? x - y : y - x;
  endfunction

  function automatic logic [DW-1:0] avg2(input logic [DW-1:0] x,
                                         input logic [DW-1:0] y);
    logic [DW:0] s;
    s    = {1'b0, x} + {1'b0, y};
    avg2 = s[DW:1];
  endfunction

  // Voting over the three snapshots, one slice per table word
  for (genvar w = 0; w < NW; w++) begin : g_vote
    assign leg_b[w] = bad_q[0] ? DEENERGIZED : ptab_q[0][w];
    assign leg_c[w] = bad_q[1] ? DEENERGIZED : ptab_q[1][w];
    if (w < NDIG) begin : g_dig
      assign voted[w] = (snap_q[w] & leg_b[w]) | (snap_q[w] & leg_c[w]) |
                        (leg_b[w] & leg_c[w]);
    end else begin : g_ana
      logic [DW-1:0] a, b, c, lim, med, lo, hi;
      logic          ab, ac, bc, dev_a, dev_b, dev_c;
      assign a   = snap_q[w];
      assign b   = leg_b[w];
      assign c   = leg_c[w];
      assign lim = ana_limit[w-NDIG];
      assign ab  = absdiff(a, b) > lim;
      assign ac  = absdiff(a, c) > lim;
      assign bc  = absdiff(b, c) > lim;
      // mid-value select; clamping keeps two equal legs chosen
      assign lo  = (a < b) ? a : b;
      assign hi  = (a < b) ? b : a;
      assign med = (c < lo) ? lo : ((c > hi) ? hi : c);
      assign dev_a = ab && ac && !bc;
      assign dev_b = ab && bc && !ac;
      assign dev_c = ac && bc && !ab;
      assign dev_alarm[w-NDIG] = dev_a || dev_b || dev_c;
      assign voted[w] = dev_a ? avg2(b, c) :
                        dev_b ? avg2(a, c) :
                        dev_c ? avg2(a, b) : med;
    end
  end

  assign all_in = (bad_q[0] || pcnt_q[0] == 3'(NW)) &&
                  (bad_q[1] || pcnt_q[1] == 3'(NW)) && tcnt_q == 3'(NW) &&
                  !txv_q;
  assign push   = (sst_q == S_OUT) && buf_ready;

  // Scan sequencer: snapshot, exchange, vote, stream the voted table
  always_comb begin
    sst_d  = sst_q;
    snap_d = snap_q;
    ptab_d = ptab_q;
    pcnt_d = pcnt_q;
    bad_d  = bad_q;
    tcnt_d = tcnt_q;
    ocnt_d = ocnt_q;
    stmr_d = stmr_q;
    txv_d  = txv_q;
    txd_d  = txd_q;
    done_d = 1'b0;
    alm_d  = alm_q;
    case (sst_q)
      S_IDLE: begin
        if (scan_time_sync) begin
          snap_d = itab_q;
          pcnt_d = '{default: '0};
          bad_d  = 2'b00;
          tcnt_d = '0;
          stmr_d = 12'h000;
          sst_d  = S_XCHG;
        end
      end
      S_XCHG: begin
        stmr_d = stmr_q + 12'h001;
        if (txv_q && tx_ready) txv_d = 1'b0;
        if ((!txv_q || tx_ready) && tcnt_q != 3'(NW)) begin
          txv_d  = 1'b1;
          txd_d  = snap_q[tcnt_q[IW-1:0]];
          tcnt_d = tcnt_q + 3'h1;
        end
        for (int p = 0; p < NPEER; p++) begin
          if (peer_rx[p].valid && !bad_q[p] && pcnt_q[p] != 3'(NW)) begin
            if (peer_rx[p].crc_ok) begin
              ptab_d[p][pcnt_q[p][IW-1:0]] = peer_rx[p].data;
              pcnt_d[p] = pcnt_q[p] + 3'h1;
            end else begin
              bad_d[p] = 1'b1;
            end
          end
        end
        if (all_in) begin
          sst_d = S_VOTE;
        end else if (stmr_q >= PEER_WIN_CYC) begin
          for (int p = 0; p < NPEER; p++)
            if (pcnt_q[p] != 3'(NW)) bad_d[p] = 1'b1;
          txv_d = 1'b0;
          sst_d = S_VOTE;
        end
      end
      S_VOTE: begin
        // Peer flags are settled here, so the vote is stable from now on
        alm_d  = dev_alarm;
        ocnt_d = '0;
        sst_d  = S_OUT;
      end
      S_OUT: begin
        if (push) begin
          ocnt_d = ocnt_q + 2'h1;
          if (ocnt_q == 2'(NW - 1)) begin
            done_d = 1'b1;
            sst_d  = S_IDLE;
          end
        end
      end
      default: sst_d = S_IDLE;
    endcase
  end

  // Scan registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sst_q  <= S_IDLE;
      snap_q <= '{default: DEENERGIZED};
      ptab_q <= '{default: '{default: DEENERGIZED}};
      pcnt_q <= '{default: '0};
      bad_q  <= 2'b11;
      tcnt_q <= '0;
      ocnt_q <= '0;
      stmr_q <= 12'h000;
      txv_q  <= 1'b0;
      txd_q  <= '0;
      done_q <= 1'b0;
      alm_q  <= '0;
    end else begin
      sst_q  <= sst_d;
      snap_q <= snap_d;
      ptab_q <= ptab_d;
      pcnt_q <= pcnt_d;
      bad_q  <= bad_d;
      tcnt_q <= tcnt_d;
      ocnt_q <= ocnt_d;
      stmr_q <= stmr_d;
      txv_q  <= txv_d;
      txd_q  <= txd_d;
      done_q <= done_d;
      alm_q  <= alm_d;
    end
  end

  assign tx_valid  = txv_q;
  assign tx_data   = txd_q;
  assign ana_alarm = alm_q;
  assign peer_bad  = bad_q;
  assign scan_done = done_q;

  logic                  hv_q, hv_d, sv_q, sv_d;
  logic [DW-1:0]         hd_q, hd_d, sd_q, sd_d;
  logic                  pop;

  // Two-entry buffer: head drives the port, spare catches a stalled word
  assign pop       = hv_q && vote_ready;
  assign buf_ready = !sv_q;
  always_comb begin
    hv_d = hv_q;
    hd_d = hd_q;
    sv_d = sv_q;
    sd_d = sd_q;
    if (pop || !hv_q) begin
      if (sv_q) begin
        hv_d = 1'b1;
        hd_d = sd_q;
        sv_d = 1'b0;
        if (push) begin
          sv_d = 1'b1;
          sd_d = voted[ocnt_q];
        end
      end else begin
        hv_d = push;
        hd_d = voted[ocnt_q];
      end
    end else if (push) begin
      sv_d = 1'b1;
      sd_d = voted[ocnt_q];
    end
  end

  // Buffer registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hv_q <= 1'b0;
      hd_q <= '0;
      sv_q <= 1'b0;
      sd_q <= '0;
    end else begin
      hv_q <= hv_d;
      hd_q <= hd_d;
      sv_q <= sv_d;
      sd_q <= sd_d;
    end
  end

  assign vote_valid = hv_q;
  assign vote_data  = hd_q;
endmodule
`default_nettype wire

// File: include/tmr_vote_pkg.sv
// Shared constants and carrier types for the voted input table block
package tmr_vote_pkg;
  localparam int          DW             = 16;   // Width of one table word
  localparam int          NW             = 4;    // Input table words
  localparam int          NDIG           = 2;    // Words 0..NDIG-1 digital
  localparam int          NANA           = NW - NDIG;
  localparam int          IW             = 2;    // Word index width
  localparam int          NPEER          = 2;
  localparam logic [1:0]  MAX_RETRY      = 2'h3; // Repeats after the first
  localparam logic [DW-1:0] DEENERGIZED  = 16'h0000;
  localparam int          CLK_PERIOD_PS  = 4000;
  localparam int          IO_TIMEOUT_NS  = 1000;
  localparam int          PEER_WINDOW_NS = 8000;
  // Longest waits, rounded down to whole cycles
  localparam logic [11:0] IO_TIMEOUT_CYC =
    12'((IO_TIMEOUT_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [11:0] PEER_WIN_CYC   =
    12'((PEER_WINDOW_NS * 1000) / CLK_PERIOD_PS);

  typedef struct packed {
    logic          valid;
    logic          crc_ok;
    logic [DW-1:0] data;
  } word_in_t;

  typedef enum logic [1:0] {
    P_SEND = 2'b01,
    P_WAIT = 2'b10
  } poll_st_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_XCHG = 4'b0010,
    S_VOTE = 4'b0100,
    S_OUT  = 4'b1000
  } scan_st_t;
endpackage

// File: tb/io_leg_model.sv
// Leg model of the input modules, answering each poll two cycles later
`timescale 1ns/100ps
`default_nettype none
module io_leg_model (
  input  wire logic                        mclk,
  input  wire logic                        io_req_valid,
  input  wire logic [tmr_vote_pkg::IW-1:0] io_req_addr,
  output var  tmr_vote_pkg::word_in_t      io_rsp
);
  import tmr_vote_pkg::*;
  logic [DW-1:0] val [NW];
  int            nbad [NW];
  logic          mute [NW];
  int            run = 0;
  int            maxrun = 0;
  logic          p1 = 1'b0;
  logic [IW-1:0] a1 = 2'h0;
  logic [IW-1:0] lr = 2'h0;
  initial begin
    io_rsp = '0;
    foreach (nbad[i]) begin
      nbad[i] = 0;
      mute[i] = 1'b0;
      val[i] = 16'h0000;
    end
  end
  // answer carries a check flag; idle bus toggles, a muted module is lost
  always @(posedge mclk) begin
    p1 <= io_req_valid;
    a1 <= io_req_addr;
    if (p1 && !mute[a1])
      io_rsp <= '{1'b1, nbad[a1] == 0, val[a1]};
    else
      io_rsp <= '{1'b0, 1'b0, ~io_rsp.data};
    if (p1 && !mute[a1] && nbad[a1] > 0)
      nbad[a1] = nbad[a1] - 1;
    // Requests in a row to one module, not cycles spent on it
    if (io_req_valid) begin
      run = (io_req_addr == lr) ? run + 1 : 1;
      lr = io_req_addr;
    end
    if (run > maxrun)
      maxrun = run;
  end
endmodule
`default_nettype wire

// File: tb/tb_tmr_input_table_voter.sv
// Random and corner-case bench for the voted input table block
`timescale 1ns/100ps
`default_nettype none
module tb_tmr_input_table_voter;
  import tmr_vote_pkg::*;
  logic mclk, nrst, scan_time_sync, tx_ready, vote_ready, io_req_valid;
  logic tx_valid, scan_done, vote_valid;
  logic [IW-1:0] io_req_addr;
  logic [DW-1:0] tx_data, vote_data, own [NW], ev [NW], pw [2][NW];
  logic [NANA-1:0] ana_alarm, ea;
  logic [1:0] peer_bad;
  logic [NANA-1:0][DW-1:0] ana_limit;
  word_in_t io_rsp, peer_rx [2];
  logic [31:0] seed = 32'hbd50db2b;
  int fails = 0;
  int n_checks = 0;
  tmr_input_table_voter DUT (.mclk, .nrst, .io_req_valid, .io_req_addr,
    .io_rsp, .scan_time_sync, .tx_valid, .tx_data, .tx_ready, .peer_rx,
    .ana_limit, .ana_alarm, .peer_bad, .scan_done, .vote_valid, .vote_data,
    .vote_ready);
  io_leg_model leg (.mclk, .io_req_valid, .io_req_addr, .io_rsp);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [DW-1:0] dif(logic [DW-1:0] x, y);
    return x > y ? x - y : y - x;
  endfunction
  // Deviant leg gives way to the mean of the other two, else the median
  function automatic logic [DW:0] vote_ana(logic [DW-1:0] a, b, c, l);
    logic [DW-1:0] t;
    logic [DW:0] s;
    for (int i = 0; i < 3; i++) begin
      s = {1'b0, b} + {1'b0, c};
      if (dif(a, b) > l && dif(a, c) > l && dif(b, c) <= l)
        return {1'b1, s[DW:1]};
      t = a;
      a = b;
      b = c;
      c = t;
    end
    return {1'b0, a > b ? (b > c ? b : (a > c ? c : a))
                        : (a > c ? a : (b > c ? c : b))};
  endfunction
  task automatic cmp(string n, logic [DW-1:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Mode 1 spoils a peer word, 2 silences a peer, 3 mutes module 2
  // and spoils every answer of module 3
  task automatic run_scan(int mode);
    int nt, nv;
    logic [DW-1:0] a, b, c;
    logic [DW:0] r;
    nt = 0;
    nv = 0;
    // Module 1 answers on its last allowed try every scan
    for (int k = 0; k < NW; k++) begin
      leg.val[k] = DW'(rnd());
      leg.nbad[k] = (k == 1) ? 3 : ((mode == 3 && k == 3) ? 99999 : 0);
      leg.mute[k] = (mode == 3 && k == 2);
      own[k] = (leg.nbad[k] > 3 || leg.mute[k]) ? DEENERGIZED : leg.val[k];
      pw[0][k] = DW'(rnd());
      pw[1][k] = DW'(rnd());
    end
    ana_limit = {DW'(rnd() >> 20) | 16'h0010, DW'(rnd() >> 20) | 16'h0010};
    if (mode == 0)
      pw[0][2] = own[2] + 16'h0001;
    for (int k = 0; k < NW; k++) begin
      a = own[k];
      b = mode == 1 ? DEENERGIZED : pw[0][k];
      c = mode == 2 ? DEENERGIZED : pw[1][k];
      r = vote_ana(a, b, c, ana_limit[k % NANA]);
      ev[k] = k < NDIG ? (a & b) | (a & c) | (b & c) : r[DW-1:0];
      if (k >= NDIG)
        ea[k - NDIG] = r[DW];
    end
    // A muted module needs four full timeouts before its entry is cleared
    repeat (mode == 3 ? 2600 : 600) @(negedge mclk);
    scan_time_sync = 1'b1;
    @(negedge mclk);
    scan_time_sync = 1'b0;
    fork
      // peers send four words, released lines toggle
      for (int k = 0; k < NW; k++) begin
        @(negedge mclk);
        peer_rx[0] = '{1'b1, !(mode == 1 && k == 1), pw[0][k]};
        peer_rx[1] = '{mode != 2, 1'b1, pw[1][k]};
        @(negedge mclk);
        peer_rx[0] = '{1'b0, 1'b0, ~pw[0][k]};
        peer_rx[1] = '{1'b0, 1'b0, ~pw[1][k]};
      end
      for (int i = 0; nt < NW && i < 400; i++) begin
        // Word shown now is taken at the coming rising edge
        @(negedge mclk);
        tx_ready = 1'(rnd());
        if (tx_valid === 1'b1 && tx_ready) begin
          cmp("tx_data", own[nt], tx_data);
          nt++;
        end
      end
      for (int i = 0; nv < NW && i < 3000; i++) begin
        @(negedge mclk);
        vote_ready = 1'(rnd());
        if (vote_valid === 1'b1 && vote_ready) begin
          cmp("vote_data", ev[nv], vote_data);
          nv++;
        end
      end
    join
    if (nt < NW || nv < NW) begin
      cmp("words_done", 16'h0008, DW'(nt + nv));
      tally_and_finish();
    end
    cmp("ana_alarm", 16'(ea), 16'(ana_alarm));
    cmp("peer_bad", {14'h0000, mode == 2, mode == 1}, 16'(peer_bad));
    cmp("tries", 16'h0004, DW'(leg.maxrun));
  endtask
  initial begin
    nrst = 1'b0;
    scan_time_sync = 1'b0;
    tx_ready = 1'b0;
    vote_ready = 1'b0;
    ana_limit = '0;
    peer_rx[0] = '0;
    peer_rx[1] = '0;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    // Straight after reset both peer tables count as failed
    cmp("peer_bad", 16'h0003, 16'(peer_bad));
    for (int s = 0; s < 8; s++)
      run_scan(s % 4);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: tb/tmr_voter_chk_sva.sv
// Port assertions for the voted input table block
`timescale 1ns/100ps
`default_nettype none
module tmr_voter_chk (
  input wire logic                        mclk,
  input wire logic                        nrst,
  input wire logic                        io_req_valid,
  input wire logic [tmr_vote_pkg::IW-1:0] io_req_addr,
  input wire tmr_vote_pkg::word_in_t      io_rsp,
  input wire logic                        tx_valid,
  input wire logic [tmr_vote_pkg::DW-1:0] tx_data,
  input wire logic                        tx_ready,
  input wire logic                        scan_done,
  input wire logic                        vote_valid,
  input wire logic [tmr_vote_pkg::DW-1:0] vote_data,
  input wire logic                        vote_ready
);
  import tmr_vote_pkg::*;
  logic [2:0]    tries_q, tries_d;
  logic [IW-1:0] last_q, last_d;
  // Tries in a row at one module; the address is the only mark we see
  always_comb begin
    tries_d = tries_q;
    last_d = last_q;
    if (io_req_valid) begin
      tries_d = (io_req_addr == last_q) ? tries_q + 3'h1 : 3'h1;
      last_d = io_req_addr;
    end
  end
  always_ff @(posedge mclk) begin
    tries_q <= nrst ? tries_d : 3'h0;
    last_q <= nrst ? last_d : 2'h0;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence s_good_rsp;
    io_rsp.valid && io_rsp.crc_ok;
  endsequence
  // New request goes out two edges after the answer is taken
  sequence s_next_req;
    ##2 io_req_valid && io_req_addr == $past(io_req_addr, 2) + 2'h1;
  endsequence
  chk_good_next: assert property (s_good_rsp |-> s_next_req)
    else $error("poll did not move on after a good answer");
  chk_addr_step: assert property ($past(nrst) &&
    $changed(io_req_addr) |-> io_req_addr == $past(io_req_addr) + 2'h1)
    else $error("poll address skipped");
  chk_req_pulse: assert property (io_req_valid |=> !io_req_valid)
    else $error("poll request longer than a cycle");
  chk_retry_next: assert property (io_rsp.valid &&
    !io_rsp.crc_ok |-> ##[1:4] io_req_valid)
    else $error("no new try after a bad answer");
  chk_tries_max: assert property (tries_q <= 3'h4)
    else $error("more than four tries at one module");
  chk_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data))
    else $error("snapshot word dropped before taken");
  chk_vote_hold: assert property (vote_valid && !vote_ready
    |=> vote_valid && $stable(vote_data))
    else $error("voted word dropped before taken");
  chk_done_pulse: assert property (scan_done |=> !scan_done)
    else $error("scan end longer than a cycle");
endmodule
bind tmr_input_table_voter tmr_voter_chk u_chk (.mclk, .nrst,
  .io_req_valid, .io_req_addr, .io_rsp, .tx_valid, .tx_data, .tx_ready,
  .scan_done, .vote_valid, .vote_data, .vote_ready);
`default_nettype wire
